/* verilog/stq_pkg.sv */
// Shared constants of the analog-chain self-test sequencer.
// Assumes one 10 MHz system clock; all voltages are integers in millivolts.
package stq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Pass windows, in millivolts
  // ****************************************************************
  localparam logic [15:0] MV_PER_STEP = 16'h03E8;
  localparam logic [15:0] LO_PER_STEP = 16'h03B6;
  localparam logic [15:0] HI_PER_STEP = 16'h041A;
  localparam logic [15:0] ZERO_HI_MV  = 16'h0032;

  // ****************************************************************
  // Test groups, error numbers and answers
  // ****************************************************************
  localparam logic [2:0]  GRP_OUT_DAC = 3'h0;
  localparam logic [2:0]  GRP_OFS_DAC = 3'h1;
  localparam logic [2:0]  GRP_CAL_DAC = 3'h2;
  localparam logic [2:0]  GRP_AMP1    = 3'h3;
  localparam logic [2:0]  GRP_AMP2    = 3'h4;
  localparam logic [9:0]  BASE_OUT    = 10'h064;
  localparam logic [9:0]  BASE_OFS    = 10'h0C8;
  localparam logic [9:0]  BASE_CAL    = 10'h190;
  localparam logic [9:0]  BASE_AMP1   = 10'h258;
  localparam logic [9:0]  BASE_AMP2   = 10'h320;
  localparam logic [3:0]  LAST_LONG   = 4'hA;
  localparam logic [3:0]  LAST_SHORT  = 4'h5;
  localparam logic [1:0]  CONV_OUT    = 2'h0;
  localparam logic [1:0]  CONV_OFS    = 2'h1;
  localparam logic [1:0]  CONV_CAL    = 2'h2;
  localparam logic [1:0]  MEAS_DAC    = 2'h0;
  localparam logic [1:0]  MEAS_AMP1   = 2'h1;
  localparam logic [1:0]  MEAS_AMP2   = 2'h2;
  localparam logic signed [15:0] ERR_SELF_TEST = -16'sh012C;
  localparam logic signed [15:0] ERR_NONE      = 16'sh0000;
  localparam logic        RESULT_PASS = 1'h0;
  localparam logic        RESULT_FAIL = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DRIVE  = 3'h1,
    ST_SETTLE = 3'h3,
    ST_CONV   = 3'h2,
    ST_CHECK  = 3'h6,
    ST_NEXT   = 3'h7,
    ST_DONE   = 3'h5
  } stq_state_e;

endpackage

/* verilog/stq_self_test.sv */
// Self-test sequencer: steps the converters and amplifier stages, checks each ADC reading.
// Assumes query, error-read and ADC handshake come from logic on sys_clk.
//
// Summary of operation
// - Self-test answer is 0 pass, 1 fail
// - Failure lamp stays lit until error read
// - Error read after failure yields code -300
// - All nominals and limits are in millivolts
// - Output DAC 0..10 V, errors 100..110
// - Reading outside window sets that level's error
// - Offset DAC 0..5 V, errors 200..205
// - Calibrator DAC 0..10 V, errors 400..410
// - Amp stage 1 via offset DAC, 600..605
// - Amp stage 2 at unity gain, 800..805
// - Windows 0..50 at zero, else 95..105%
module stq_self_test (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                tst_query,
  input  wire logic                err_read,
  input  wire logic                adc_done,
  input  wire logic [15:0]         adc_mv,
  output logic                     busy_q,
  output logic                     tst_done_q,
  output logic                     tst_result_q,
  output logic                     lamp_q,
  output logic                     err_valid_q,
  output logic signed [15:0]       err_code_q,
  output logic                     err_num_stb_q,
  output logic [9:0]               err_num_q,
  output logic [1:0]               dac_sel_q,
  output logic [15:0]              dac_mv_q,
  output logic [1:0]               meas_sel_q,
  output logic                     amp2_gain_one_q,
  output logic                     adc_start_q
);

  // ****************************************************************
  // Group decoding
  // ****************************************************************
  function automatic logic [9:0] grp_base(input logic [2:0] g);
    case (g)
      stq_pkg::GRP_OUT_DAC: grp_base = stq_pkg::BASE_OUT;
      stq_pkg::GRP_OFS_DAC: grp_base = stq_pkg::BASE_OFS;
      stq_pkg::GRP_CAL_DAC: grp_base = stq_pkg::BASE_CAL;
      stq_pkg::GRP_AMP1:    grp_base = stq_pkg::BASE_AMP1;
      default:              grp_base = stq_pkg::BASE_AMP2;
    endcase
  endfunction

  function automatic logic [3:0] grp_last(input logic [2:0] g);
    if (g == stq_pkg::GRP_OUT_DAC || g == stq_pkg::GRP_CAL_DAC) begin
      grp_last = stq_pkg::LAST_LONG;
    end else begin
      grp_last = stq_pkg::LAST_SHORT;
    end
  endfunction

  function automatic logic [1:0] grp_conv(input logic [2:0] g);
    case (g)
      stq_pkg::GRP_OUT_DAC: grp_conv = stq_pkg::CONV_OUT;
      stq_pkg::GRP_CAL_DAC: grp_conv = stq_pkg::CONV_CAL;
      default:              grp_conv = stq_pkg::CONV_OFS;
    endcase
  endfunction

  function automatic logic [1:0] grp_meas(input logic [2:0] g);
    case (g)
      stq_pkg::GRP_AMP1: grp_meas = stq_pkg::MEAS_AMP1;
      stq_pkg::GRP_AMP2: grp_meas = stq_pkg::MEAS_AMP2;
      default:           grp_meas = stq_pkg::MEAS_DAC;
    endcase
  endfunction

  function automatic logic in_window(input logic [3:0] lvl, input logic [15:0] mv);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = 16'(lvl) * stq_pkg::LO_PER_STEP;
    hi = (lvl == 4'h0) ? stq_pkg::ZERO_HI_MV : 16'(16'(lvl) * stq_pkg::HI_PER_STEP);
    in_window = (mv >= lo) && (mv <= hi);
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  stq_pkg::stq_state_e state_q, state_d;
  logic [2:0]  grp_q, grp_d;
  logic [3:0]  lvl_q, lvl_d;
  logic [6:0]  cnt_q, cnt_d;
  logic [15:0] adc_q, adc_d;
  logic        fail_q, fail_d;
  logic        busy_d, tst_done_d, tst_result_d, err_num_stb_d, adc_start_d, amp2_gain_one_d;
  logic [9:0]  err_num_d;
  logic [1:0]  dac_sel_d, meas_sel_d;
  logic [15:0] dac_mv_d;
  logic        fin_fail;

  always_comb begin
    state_d         = state_q;
    grp_d           = grp_q;
    lvl_d           = lvl_q;
    cnt_d           = cnt_q;
    adc_d           = adc_q;
    fail_d          = fail_q;
    busy_d          = busy_q;
    tst_done_d      = 1'b0;
    tst_result_d    = tst_result_q;
    err_num_stb_d   = 1'b0;
    err_num_d       = err_num_q;
    dac_sel_d       = dac_sel_q;
    dac_mv_d        = dac_mv_q;
    meas_sel_d      = meas_sel_q;
    amp2_gain_one_d = amp2_gain_one_q;
    adc_start_d     = 1'b0;
    fin_fail        = 1'b0;
    case (state_q)
      stq_pkg::ST_IDLE: begin
        if (tst_query) begin
          grp_d   = stq_pkg::GRP_OUT_DAC;
          lvl_d   = 4'h0;
          fail_d  = 1'b0;
          busy_d  = 1'b1;
          state_d = stq_pkg::ST_DRIVE;
        end
      end
      stq_pkg::ST_DRIVE: begin
        dac_sel_d       = grp_conv(grp_q);
        dac_mv_d        = 16'(16'(lvl_q) * stq_pkg::MV_PER_STEP);
        meas_sel_d      = grp_meas(grp_q);
        amp2_gain_one_d = (grp_q == stq_pkg::GRP_AMP2);
        cnt_d           = 7'h00;
        state_d         = stq_pkg::ST_SETTLE;
      end
      stq_pkg::ST_SETTLE: begin
        cnt_d = 7'(cnt_q + 7'h01);
        if (cnt_q == 7'(stq_pkg::SETTLE_CYC - 1)) begin
          adc_start_d = 1'b1;
          state_d     = stq_pkg::ST_CONV;
        end
      end
      stq_pkg::ST_CONV: begin
        if (adc_done) begin
          adc_d   = adc_mv;
          state_d = stq_pkg::ST_CHECK;
        end
      end
      stq_pkg::ST_CHECK: begin
        if (!in_window(lvl_q, adc_q)) begin
          fail_d        = 1'b1;
          err_num_stb_d = 1'b1;
          err_num_d     = 10'(grp_base(grp_q) + 10'(lvl_q));
        end
        state_d = stq_pkg::ST_NEXT;
      end
      stq_pkg::ST_NEXT: begin
        state_d = stq_pkg::ST_DRIVE;
        if (lvl_q != grp_last(grp_q)) begin
          lvl_d = 4'(lvl_q + 4'h1);
        end else if (grp_q != stq_pkg::GRP_AMP2) begin
          grp_d = 3'(grp_q + 3'h1);
          lvl_d = 4'h0;
        end else begin
          state_d = stq_pkg::ST_DONE;
        end
      end
      stq_pkg::ST_DONE: begin
        tst_done_d      = 1'b1;
        tst_result_d    = fail_q ? stq_pkg::RESULT_FAIL : stq_pkg::RESULT_PASS;
        fin_fail        = fail_q;
        busy_d          = 1'b0;
        dac_mv_d        = 16'h0000;
        amp2_gain_one_d = 1'b0;
        state_d         = stq_pkg::ST_IDLE;
      end
      default: begin
        state_d = stq_pkg::ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q         <= stq_pkg::ST_IDLE;
      grp_q           <= 3'h0;
      lvl_q           <= 4'h0;
      cnt_q           <= 7'h00;
      adc_q           <= 16'h0000;
      fail_q          <= 1'b0;
      busy_q          <= 1'b0;
      tst_done_q      <= 1'b0;
      tst_result_q    <= 1'b0;
      err_num_stb_q   <= 1'b0;
      err_num_q       <= 10'h000;
      dac_sel_q       <= 2'h0;
      dac_mv_q        <= 16'h0000;
      meas_sel_q      <= 2'h0;
      amp2_gain_one_q <= 1'b0;
      adc_start_q     <= 1'b0;
    end else begin
      state_q         <= state_d;
      grp_q           <= grp_d;
      lvl_q           <= lvl_d;
      cnt_q           <= cnt_d;
      adc_q           <= adc_d;
      fail_q          <= fail_d;
      busy_q          <= busy_d;
      tst_done_q      <= tst_done_d;
      tst_result_q    <= tst_result_d;
      err_num_stb_q   <= err_num_stb_d;
      err_num_q       <= err_num_d;
      dac_sel_q       <= dac_sel_d;
      dac_mv_q        <= dac_mv_d;
      meas_sel_q      <= meas_sel_d;
      amp2_gain_one_q <= amp2_gain_one_d;
      adc_start_q     <= adc_start_d;
    end
  end

  // ****************************************************************
  // Lamp and error queue
  // ****************************************************************
  logic                lamp_d;
  logic                err_valid_d;
  logic signed [15:0]  err_code_d;

  always_comb begin
    lamp_d      = lamp_q;
    err_valid_d = err_read;
    err_code_d  = err_code_q;
    if (err_read) begin
      lamp_d     = 1'b0;
      err_code_d = lamp_q ? stq_pkg::ERR_SELF_TEST : stq_pkg::ERR_NONE;
    end
    if (fin_fail) begin
      lamp_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lamp_q      <= 1'b0;
      err_valid_q <= 1'b0;
      err_code_q  <= 16'sh0000;
    end else begin
      lamp_q      <= lamp_d;
      err_valid_q <= err_valid_d;
      err_code_q  <= err_code_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [9:0] prev_num_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || tst_query) begin
      prev_num_q <= 10'h000;
    end else if (err_num_stb_q) begin
      prev_num_q <= err_num_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_result_fail_lamp: assert property (tst_done_q && tst_result_q |-> lamp_q)
    else $error("Failed self-test left lamp dark");
  a_result_pass_bit: assert property (state_q == stq_pkg::ST_DONE && !fail_q |=> tst_done_q && !tst_result_q)
    else $error("Passing self-test did not answer 0");
  a_lamp_holds: assert property (lamp_q && !err_read |=> lamp_q)
    else $error("Lamp dropped without an error read");
  a_lamp_clears: assert property (err_read && !fin_fail |=> !lamp_q)
    else $error("Lamp not cleared by error read");
  a_err_code_300: assert property (err_read && lamp_q |=> err_valid_q && err_code_q == -16'sd300)
    else $error("Error read after failure did not give -300");
  a_dac_level_mv: assert property (state_q == stq_pkg::ST_DRIVE |=> dac_mv_q == 16'(lvl_q) * 16'd1000)
    else $error("Converter level is not whole volts in millivolts");
  a_err_num_range: assert property (err_num_stb_q |-> (err_num_q >= 10'd100 && err_num_q <= 10'd110)
    || (err_num_q >= 10'd200 && err_num_q <= 10'd205) || (err_num_q >= 10'd400 && err_num_q <= 10'd410)
    || (err_num_q >= 10'd600 && err_num_q <= 10'd605) || (err_num_q >= 10'd800 && err_num_q <= 10'd805))
    else $error("Error number outside its test range");
  a_window_fail: assert property (state_q == stq_pkg::ST_CHECK && lvl_q != 4'h0
    && (adc_q < 16'(lvl_q) * 16'd950 || adc_q > 16'(lvl_q) * 16'd1050) |=> err_num_stb_q)
    else $error("Out-of-window reading not flagged");
  a_window_pass: assert property (state_q == stq_pkg::ST_CHECK && lvl_q == 4'h0 && adc_q <= 16'd50
    |=> !err_num_stb_q)
    else $error("Zero-level reading within 50 mV flagged");
  a_amp2_unity: assert property (adc_start_q && meas_sel_q == stq_pkg::MEAS_AMP2 |-> amp2_gain_one_q)
    else $error("Second stage measured at non-unity gain");
  a_settle_wait: assert property ($rose(state_q == stq_pkg::ST_SETTLE) |-> !adc_start_q [*8])
    else $error("Conversion started before settling");
  a_ascending_order: assert property (err_num_stb_q && prev_num_q != 10'h000 |-> err_num_q > prev_num_q)
    else $error("Error numbers not ascending");

  c_pass_run: cover property (tst_done_q && !tst_result_q);
  c_fail_run: cover property (tst_done_q && tst_result_q);
  c_read_clear: cover property (lamp_q && err_read ##1 !lamp_q);
  c_amp2_fail: cover property (err_num_stb_q && err_num_q >= 10'd800);

endmodule // stq_self_test

/* verif/stq_adc_model.sv */
// ADC model for the self-test sequencer: answers each conversion request.
// Assumes the bench picks latency and one faulty conversion, or all faulty; drives on falling edges.
module stq_adc_model (
  input  wire logic        sys_clk,
  input  wire logic        adc_start_q,
  input  wire logic [15:0] dac_mv_q,
  input  wire logic        tst_done_q,
  input  wire logic [3:0]  lat,
  input  wire logic [5:0]  fault_idx,
  input  wire logic [15:0] fault_mv,
  input  wire logic        all_bad,
  output logic             adc_done = 1'b0,
  output logic [15:0]      adc_mv = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Conversion timing
  // ********************
  logic [3:0]  cnt = 4'h0;
  logic [5:0]  idx = 6'h00;
  logic [15:0] val = 16'h0000;
  always @(negedge sys_clk) begin
    adc_done <= 1'b0;
    // Reading is inverted every cycle outside the done cycle
    adc_mv   <= ~adc_mv;
    if (tst_done_q) begin
      idx <= 6'h00;
    end
    if (adc_start_q) begin
      cnt <= lat;
      val <= (all_bad || idx == fault_idx) ? fault_mv : dac_mv_q;
      idx <= idx + 6'h01;
    end else if (cnt == 4'h1) begin
      adc_done <= 1'b1;
      adc_mv   <= val;
      cnt      <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // stq_adc_model

/* verif/dac_self_test_sequencer_test.sv */
// Self-checking bench of the self-test sequencer with an ADC model.
// Assumes the sequencer and ADC model files are compiled first.
module dac_self_test_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Signals and tables
  // ********************
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               tst_query = 1'b0;
  logic               err_read = 1'b0;
  logic               adc_done, busy_q, tst_done_q, tst_result_q, lamp_q, err_valid_q;
  logic               err_num_stb_q, amp2_gain_one_q, adc_start_q;
  logic signed [15:0] err_code_q;
  logic [9:0]         err_num_q;
  logic [1:0]         dac_sel_q, meas_sel_q;
  logic [15:0]        dac_mv_q, adc_mv;
  logic [3:0]         lat = 4'h1;
  logic [5:0]         fault_idx = 6'h3F;
  logic [15:0]        fault_mv = 16'h0000;
  logic               all_bad = 1'b0;
  int                 fail_count = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  int                 n_conv = 0;
  int                 n_err = 0;
  logic [9:0]         last_err = 10'h000;
  logic [4:0]         s_ctl [64];
  logic [15:0]        s_mv [64];
  localparam int         GF [5] = '{0, 11, 17, 28, 34};
  localparam logic [9:0] GB [5] = '{10'h064, 10'h0C8, 10'h190, 10'h258, 10'h320};
  localparam logic [1:0] GS [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1};
  localparam logic [1:0] GM [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  localparam int         WI [14] = '{0, 0, 1, 1, 1, 1, 10, 16, 27, 28, 33, 38, 34, 11};
  localparam int         WM [14] = '{50, 51, 949, 950, 1050, 1051, 10501, 5251, 9499, 50, 4749, 5250, 51, 0};

  stq_self_test u_stq_self_test (.sys_clk, .rst_n, .tst_query, .err_read, .adc_done, .adc_mv,
    .busy_q, .tst_done_q, .tst_result_q, .lamp_q, .err_valid_q, .err_code_q, .err_num_stb_q,
    .err_num_q, .dac_sel_q, .dac_mv_q, .meas_sel_q, .amp2_gain_one_q, .adc_start_q);
  stq_adc_model u_stq_adc_model (.sys_clk, .adc_start_q, .dac_mv_q, .tst_done_q, .lat,
    .fault_idx, .fault_mv, .all_bad, .adc_done, .adc_mv);

  always #50 sys_clk = ~sys_clk;

  // ********************
  // Monitor and timeout
  // ********************
  always @(negedge sys_clk) begin
    cycles++;
    if (adc_start_q === 1'b1) begin
      s_ctl[n_conv[5:0]] = {dac_sel_q, meas_sel_q, amp2_gain_one_q};
      s_mv[n_conv[5:0]] = dac_mv_q;
      n_conv++;
    end
    if (err_num_stb_q === 1'b1) begin
      n_err++;
      last_err = err_num_q;
    end
    if (cycles == 90000) begin
      fail_count++;
      complete_run();
    end
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic int grp(input int i);
    int g;
    g = 0;
    for (int j = 1; j < 5; j++) begin
      if (i >= GF[j]) g = j;
    end
    return g;
  endfunction

  task automatic run(input int l, input int fi, input int fm);
    @(negedge sys_clk);
    lat = 4'(l);
    fault_idx = 6'(fi);
    fault_mv = 16'(fm);
    n_conv = 0;
    n_err = 0;
    tst_query = 1'b1;
    @(negedge sys_clk);
    tst_query = 1'b0;
    repeat (300) @(negedge sys_clk);
    check(busy_q, 1);
    // Second query while busy must be ignored
    tst_query = 1'b1;
    @(negedge sys_clk);
    tst_query = 1'b0;
    for (int w = 0; w < 6000 && tst_done_q !== 1'b1; w++) @(negedge sys_clk);
    check(tst_done_q, 1);
    check(busy_q, 0);
    check(n_conv, 40);
  endtask

  task automatic rd_err(input logic signed [15:0] code);
    @(negedge sys_clk);
    err_read = 1'b1;
    @(negedge sys_clk);
    err_read = 1'b0;
    check(err_valid_q, 1);
    check({16'h0000, err_code_q}, {16'h0000, code});
    check(lamp_q, 0);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic test_nominal();
    int g;
    run(1, 63, 0);
    check(tst_result_q, 0);
    check(lamp_q, 0);
    check(n_err, 0);
    check(dac_mv_q, 0);
    for (int i = 0; i < 40; i++) begin
      g = grp(i);
      check(s_ctl[i], {GS[g], GM[g], g == 4});
      check(s_mv[i], 16'(i - GF[g]) * stq_pkg::MV_PER_STEP);
    end
    $display("test_nominal finished");
  endtask

  // Every reading at 0 mV: only the zero levels pass, all others fail in order
  task automatic test_all_low();
    all_bad = 1'b1;
    run(1, 63, 0);
    all_bad = 1'b0;
    check(tst_result_q, 1);
    check(n_err, 35);
    check(last_err, 10'h325);
    check(lamp_q, 1);
    rd_err(stq_pkg::ERR_SELF_TEST);
    $display("test_all_low finished");
  endtask

  task automatic test_windows();
    int g;
    int k;
    int f;
    for (int t = 0; t < 14; t++) begin
      g = grp(WI[t]);
      k = WI[t] - GF[g];
      f = (WM[t] < k * 950 || WM[t] > (k == 0 ? 50 : k * 1050)) ? 1 : 0;
      run((t % 2) ? 7 : 1, WI[t], WM[t]);
      check(tst_result_q, f);
      check(n_err, f);
      if (f == 1) check(last_err, GB[g] + 10'(k));
      repeat (20) @(negedge sys_clk);
      check(lamp_q, f);
      rd_err(f == 1 ? stq_pkg::ERR_SELF_TEST : stq_pkg::ERR_NONE);
      rd_err(stq_pkg::ERR_NONE);
    end
    $display("test_windows finished");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    test_nominal();
    test_all_low();
    test_windows();
    complete_run();
  end
endmodule // dac_self_test_sequencer_test
